/* rtl/erecc_mem_if.sv */
// interface: one simple dual-port memory, write side and read side
`timescale 1ns/1ns
interface erecc_mem_if #(
  parameter int W  = 8,
  parameter int AW = 4
);
  logic          wrEn;
  logic [AW-1:0] wrAddr;
  logic [W-1:0]  wrData;
  logic          rdEn;
  logic [AW-1:0] rdAddr;
  logic [W-1:0]  rdData;

  modport user (output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
  modport mem  (input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface

/* rtl/erecc_pkg.sv */
// package: sizes, latencies and the shared error-code functions
// Function
// - correct read data on the output path; the array itself is never rewritten
// - narrow style corrects single, double- and triple-adjacent bit errors per word
// - two or more non-adjacent errors in a narrow word carry no guarantee
// - narrow-style correction exists only in 32-bit simple dual-port use
// - optional pipeline stage before the decoder adds exactly one cycle
// - narrow style gives error-seen and uncorrectable flags beside read data
// - wide style corrects any single and detects any double error per word
// - wide-style correction exists only in 64-bit simple dual-port use
// - each of eight wide channels drives its own corrected and detected flags
package erecc_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int A_DATA_W  = 32;
  localparam int A_LANES   = 3;
  localparam int A_LANE_D  = 11;
  localparam int A_LANE_P  = 15;
  localparam int A_LANE_W  = 16;
  localparam int A_CODE_W  = A_LANES * A_LANE_W;
  localparam int A_ADDR_W  = 9;
  localparam int B_CHANS   = 8;
  localparam int B_DATA_W  = 64;
  localparam int B_POS_MAX = 71;
  localparam int B_CODE_W  = 72;
  localparam int B_ADDR_W  = 8;
  localparam int HAM_CHK   = 7;

  // ****************************************************************
  // latencies, read request to data at the outputs
  // ****************************************************************
  localparam int LAT_BASE  = 2;
  localparam int LAT_PIPE  = 3;

  typedef struct packed {
    logic [B_DATA_W-1:0] data;
    logic                err;
    logic                unc;
  } erecc_dec_s;

  // extended hamming: bit 0 overall parity, checks at powers of two
  function automatic logic [B_CODE_W-1:0] eccEncode(
    input logic [B_DATA_W-1:0] d,
    input int                  nd
  );
    logic [B_CODE_W-1:0] c;
    logic                par;
    int                  k;
    c = '0;
    k = 0;
    for (int j = 1; j < B_CODE_W; j++) begin
      if (((j & (j - 1)) != 0) && (k < nd)) begin
        c[j] = d[k];
        k++;
      end
    end
    for (int p = 0; p < HAM_CHK; p++) begin
      par = 1'b0;
      for (int j = 1; j < B_CODE_W; j++) begin
        if (((j >> p) & 1) == 1) par = par ^ c[j];
      end
      c[1 << p] = par;
    end
    c[0] = ^c[B_CODE_W-1:1];
    return c;
  endfunction

  // np: highest code position in use; a syndrome beyond it is a
  // multi-bit error that aliased, so it is reported, not "fixed"
  function automatic erecc_dec_s eccDecode(
    input logic [B_CODE_W-1:0] cw,
    input int                  nd,
    input int                  np
  );
    erecc_dec_s          r;
    logic [B_CODE_W-1:0] c;
    logic [HAM_CHK-1:0]  s;
    logic                ov;
    int                  k;
    c  = cw;
    s  = '0;
    ov = ^cw;
    k  = 0;
    r  = '0;
    for (int j = 1; j < B_CODE_W; j++) begin
      if (c[j]) s = s ^ HAM_CHK'(j);
    end
    r.err = ov | (s != '0);
    if (ov && (int'(s) <= np)) c[s] = ~c[s];
    else if (r.err) r.unc = 1'b1;
    for (int j = 1; j < B_CODE_W; j++) begin
      if (((j & (j - 1)) != 0) && (k < nd)) begin
        r.data[k] = c[j];
        k++;
      end
    end
    return r;
  endfunction

endpackage

/* rtl/erecc_ram.sv */
// simple dual-port array with registered read data, no reset on contents
`timescale 1ns/1ns
module erecc_ram #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  // clock
  input wire logic core_clk,
  // ports
  erecc_mem_if.mem port
);

  logic [W-1:0] mem [2**AW];
  logic [W-1:0] rdData_q;

  always_ff @(posedge core_clk) begin
    if (port.wrEn) mem[port.wrAddr] <= port.wrData;
  end

  // read-during-write to one address returns the old word
  always_ff @(posedge core_clk) begin
    if (port.rdEn) rdData_q <= mem[port.rdAddr];
  end

  assign port.rdData = rdData_q;

endmodule // erecc_ram

/* rtl/erecc_top.sv */
// top: narrow adjacent-error and wide per-channel secded memories
`timescale 1ns/1ns
module erecc_top (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  // narrow style, static configuration
  input  wire logic                        aEccEn,
  input  wire logic                        aPipeEn,
  // narrow style write port
  input  wire logic                        aWrEn,
  input  wire logic [8:0]                  aWrAddr,
  input  wire logic [31:0]                 aWrData,
  input  wire logic [47:0]                 aWrFlip,
  // narrow style read port
  input  wire logic                        aRdEn,
  input  wire logic [8:0]                  aRdAddr,
  output logic                             aRdValid,
  output logic [31:0]                      aRdData,
  output logic                             aErrFlag,
  output logic                             aUncorrectableFlag,
  // wide style, static configuration
  input  wire logic                        bEccEn,
  // wide style write ports, one per channel
  input  wire logic [7:0]                  bWrEn,
  input  wire logic [7:0][7:0]             bWrAddr,
  input  wire logic [7:0][63:0]            bWrData,
  input  wire logic [7:0][71:0]            bWrFlip,
  // wide style read ports, one per channel
  input  wire logic [7:0]                  bRdEn,
  input  wire logic [7:0][7:0]             bRdAddr,
  output logic [7:0]                       bRdValid,
  output logic [7:0][63:0]                 bRdData,
  output logic [7:0]                       bErrorCorrect,
  output logic [7:0]                       bErrorDetect
);

  // a fix limit below every code position: the decoder then corrects
  // nothing and hands back the stored data bits as they are
  localparam int NO_FIX = -1;

  // ****************************************************************
  // narrow style: three interleaved secded lanes
  // ****************************************************************
  // a burst of up to three adjacent stored bits lands in three different
  // lanes, one bit each, so every lane sees at most a single error
  erecc_mem_if #(.W(erecc_pkg::A_CODE_W), .AW(erecc_pkg::A_ADDR_W)) aMem ();

  erecc_ram #(.W(erecc_pkg::A_CODE_W), .AW(erecc_pkg::A_ADDR_W)) uRamA (
    .core_clk (core_clk),
    .port     (aMem.mem)
  );

  logic [erecc_pkg::A_CODE_W-1:0] aEnc;
  logic [erecc_pkg::A_CODE_W-1:0] aStage_q;
  logic [erecc_pkg::A_CODE_W-1:0] aDecIn;
  logic                           aV1_q;
  logic                           aV2_q;
  logic                           aDecV;
  logic [31:0]                    aDecData;
  logic                           aDecErr;
  logic                           aDecUnc;

  // ecc is only built for the 32-bit simple dual-port shape; with it off
  // the data bits pass raw and the flags stay low
  always_comb begin
    logic [erecc_pkg::B_DATA_W-1:0] d;
    logic [erecc_pkg::B_CODE_W-1:0] c;
    d    = '0;
    c    = '0;
    aEnc = '0;
    for (int l = 0; l < erecc_pkg::A_LANES; l++) begin
      d = '0;
      for (int b = 0; b < erecc_pkg::A_LANE_D; b++) begin
        if (l * erecc_pkg::A_LANE_D + b < erecc_pkg::A_DATA_W)
          d[b] = aWrData[l * erecc_pkg::A_LANE_D + b];
      end
      c = erecc_pkg::eccEncode(d, erecc_pkg::A_LANE_D);
      for (int p = 0; p < erecc_pkg::A_LANE_W; p++)
        aEnc[p * erecc_pkg::A_LANES + l] = c[p];
    end
  end

  // flip mask corrupts the stored word on purpose for fault injection
  assign aMem.wrEn   = aWrEn;
  assign aMem.wrAddr = aWrAddr;
  assign aMem.wrData = aEnc ^ aWrFlip;
  assign aMem.rdEn   = aRdEn;
  assign aMem.rdAddr = aRdAddr;

  // optional stage trades one cycle of latency for a shorter decode path
  always_ff @(posedge core_clk) begin
    aStage_q <= aMem.rdData;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      aV1_q <= 1'b0;
      aV2_q <= 1'b0;
    end else begin
      aV1_q <= aRdEn;
      aV2_q <= aV1_q;
    end
  end

  assign aDecIn = aPipeEn ? aStage_q : aMem.rdData;
  assign aDecV  = aPipeEn ? aV2_q : aV1_q;

  // correction happens only here; the array keeps the faulty word
  always_comb begin
    logic [erecc_pkg::B_CODE_W-1:0] c;
    erecc_pkg::erecc_dec_s          r;
    c        = '0;
    r        = '0;
    aDecData = '0;
    aDecErr  = 1'b0;
    aDecUnc  = 1'b0;
    for (int l = 0; l < erecc_pkg::A_LANES; l++) begin
      c = '0;
      for (int p = 0; p < erecc_pkg::A_LANE_W; p++)
        c[p] = aDecIn[p * erecc_pkg::A_LANES + l];
      r = erecc_pkg::eccDecode(c, erecc_pkg::A_LANE_D,
                               erecc_pkg::A_LANE_P);
      // ecc off: raw data bits, any stored fault shows through
      if (!aEccEn) r = erecc_pkg::eccDecode(c, erecc_pkg::A_LANE_D,
                                            NO_FIX);
      for (int b = 0; b < erecc_pkg::A_LANE_D; b++) begin
        if (l * erecc_pkg::A_LANE_D + b < erecc_pkg::A_DATA_W)
          aDecData[l * erecc_pkg::A_LANE_D + b] = r.data[b];
        else if (r.data[b])
          r.unc = 1'b1;
      end
      aDecErr = aDecErr | r.err;
      aDecUnc = aDecUnc | r.unc;
    end
    if (!aEccEn) begin
      aDecErr = 1'b0;
      aDecUnc = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      aRdValid           <= 1'b0;
      aErrFlag           <= 1'b0;
      aUncorrectableFlag <= 1'b0;
    end else begin
      aRdValid           <= aDecV;
      aErrFlag           <= aDecV & aDecErr;
      aUncorrectableFlag <= aDecV & aDecUnc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) aRdData <= '0;
    else if (aDecV) aRdData <= aDecData;
  end

  // ****************************************************************
  // wide style: eight independent secded channels
  // ****************************************************************
  for (genvar ch = 0; ch < erecc_pkg::B_CHANS; ch++) begin : gChan
    erecc_mem_if #(.W(erecc_pkg::B_CODE_W), .AW(erecc_pkg::B_ADDR_W)) bMem ();

    erecc_ram #(.W(erecc_pkg::B_CODE_W), .AW(erecc_pkg::B_ADDR_W)) uRamB (
      .core_clk (core_clk),
      .port     (bMem.mem)
    );

    logic                  bV_q;
    erecc_pkg::erecc_dec_s bDec;
    erecc_pkg::erecc_dec_s bRaw;

    assign bMem.wrEn   = bWrEn[ch];
    assign bMem.wrAddr = bWrAddr[ch];
    assign bMem.wrData = erecc_pkg::eccEncode(bWrData[ch],
                           erecc_pkg::B_DATA_W) ^ bWrFlip[ch];
    assign bMem.rdEn   = bRdEn[ch];
    assign bMem.rdAddr = bRdAddr[ch];
    assign bDec        = erecc_pkg::eccDecode(bMem.rdData,
                           erecc_pkg::B_DATA_W, erecc_pkg::B_POS_MAX);
    assign bRaw        = erecc_pkg::eccDecode(bMem.rdData,
                           erecc_pkg::B_DATA_W, NO_FIX);

    always_ff @(posedge core_clk) begin
      if (reset) begin
        bV_q              <= 1'b0;
        bRdValid[ch]      <= 1'b0;
        bErrorCorrect[ch] <= 1'b0;
        bErrorDetect[ch]  <= 1'b0;
      end else begin
        bV_q              <= bRdEn[ch];
        bRdValid[ch]      <= bV_q;
        bErrorCorrect[ch] <= bV_q & bEccEn & bDec.err & ~bDec.unc;
        bErrorDetect[ch]  <= bV_q & bEccEn & bDec.unc;
      end
    end

    // with ecc off the raw data field is returned untouched
    always_ff @(posedge core_clk) begin
      if (reset) bRdData[ch] <= '0;
      else if (bV_q) bRdData[ch] <= bEccEn ? bDec.data : bRaw.data;
    end
  end

endmodule // erecc_top

/* sim/erecc_top_checker.sv */
// checker: timing and flag relations at the memory top ports
`timescale 1ns/1ns
module erecc_top_checker (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       reset,
  // narrow style
  input wire logic       aEccEn,
  input wire logic       aPipeEn,
  input wire logic       aRdEn,
  input wire logic       aRdValid,
  input wire logic       aErrFlag,
  input wire logic       aUncorrectableFlag,
  // wide style
  input wire logic       bEccEn,
  input wire logic [7:0] bRdEn,
  input wire logic [7:0] bRdValid,
  input wire logic [7:0] bErrorCorrect,
  input wire logic [7:0] bErrorDetect
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_a_lat; aRdEn && !aPipeEn |-> ##2 aRdValid; endproperty
  a_a_lat: assert property (p_a_lat) else $error("narrow read late");
  property p_a_pipe; aRdEn && aPipeEn |-> ##3 aRdValid; endproperty
  a_a_pipe: assert property (p_a_pipe) else $error("piped read late");
  property p_a_stray;
    aRdValid |-> (aPipeEn ? $past(aRdEn, 3) : $past(aRdEn, 2));
  endproperty
  a_a_stray: assert property (p_a_stray) else $error("stray valid");
  property p_a_flag; aErrFlag || aUncorrectableFlag |-> aRdValid; endproperty
  a_a_flag: assert property (p_a_flag) else $error("flag off word");
  property p_a_unc; aUncorrectableFlag |-> aErrFlag; endproperty
  a_a_unc: assert property (p_a_unc) else $error("unc without err");
  property p_a_off; !aEccEn |-> !aErrFlag && !aUncorrectableFlag; endproperty
  a_a_off: assert property (p_a_off) else $error("flag with ecc off");
  property p_b_lat;
    bRdEn != 8'h00 |-> ##2 (bRdValid & $past(bRdEn, 2)) == $past(bRdEn, 2);
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("wide read late");
  property p_b_flag; ((bErrorCorrect | bErrorDetect) & ~bRdValid) == 8'h00;
  endproperty
  a_b_flag: assert property (p_b_flag) else $error("wide flag alone");
  property p_b_off; !bEccEn |-> (bErrorCorrect | bErrorDetect) == 8'h00;
  endproperty
  a_b_off: assert property (p_b_off) else $error("wide flag off");
endmodule // erecc_top_checker

bind erecc_top erecc_top_checker chk (.core_clk, .reset, .aEccEn, .aPipeEn,
  .aRdEn, .aRdValid, .aErrFlag, .aUncorrectableFlag, .bEccEn, .bRdEn,
  .bRdValid, .bErrorCorrect, .bErrorDetect);

/* sim/erecc_top_tb.sv */
// testbench: scoreboarded write/read traffic with injected faults
`timescale 1ns/1ns
`define ERECC_CMP(nm, ex, got) begin \
  nChecks++; \
  if ((ex) !== (got)) begin \
    errCount++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module erecc_top_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic core_clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic aEccEn = 1'b1, aPipeEn = 1'b0, bEccEn = 1'b1;
  logic [8:0] addr = '0;
  logic [63:0] data = '0;
  logic [47:0] aFlip = '0, aWrFlip;
  logic [71:0] bFlip = '0;
  logic aWrEn, aRdEn, aRdValid, aErrFlag, aUncorrectableFlag;
  logic [8:0] aWrAddr, aRdAddr;
  logic [31:0] aWrData, aRdData, seed = 32'h272e;
  logic [7:0] bWrEn, bRdEn, bRdValid, bErrorCorrect, bErrorDetect;
  logic [7:0][7:0] bWrAddr, bRdAddr;
  logic [7:0][63:0] bWrData, bRdData;
  logic [7:0][71:0] bWrFlip;
  logic [63:0] wd [16];
  logic [34:0] qa [$];
  logic [67:0] qb [$];
  int errCount = 0, nChecks = 0, w, p;

  always #5 core_clk = ~core_clk;

  erecc_user_model user (.wr, .rd, .addr, .data, .aFlip, .bFlip, .aWrEn,
    .aWrAddr, .aWrData, .aWrFlip, .aRdEn, .aRdAddr, .bWrEn, .bWrAddr,
    .bWrData, .bWrFlip, .bRdEn, .bRdAddr);
  erecc_top dut (.core_clk, .reset, .aEccEn, .aPipeEn, .aWrEn, .aWrAddr,
    .aWrData, .aWrFlip, .aRdEn, .aRdAddr, .aRdValid, .aRdData, .aErrFlag,
    .aUncorrectableFlag, .bEccEn, .bWrEn, .bWrAddr, .bWrData, .bWrFlip,
    .bRdEn, .bRdAddr, .bRdValid, .bRdData, .bErrorCorrect, .bErrorDetect);

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************************************
  // monitor: oldest note against each word that appears
  // ****************************************************************
  always @(negedge core_clk) begin
    logic [34:0] ea;
    logic [67:0] eb;
    logic [63:0] xb;
    if (aRdValid === 1'b1) begin
      ea = qa.size() ? qa.pop_front() : 'x;
      `ERECC_CMP("aflags", ea[33:32], {aErrFlag, aUncorrectableFlag})
      if (ea[34]) `ERECC_CMP("adata", ea[31:0], aRdData)
    end
    if (bRdValid !== 8'h00) begin
      eb = qb.size() ? qb.pop_front() : 'x;
      `ERECC_CMP("bvalid", 8'hff, bRdValid)
      `ERECC_CMP("bcorrect", {8{eb[65]}}, bErrorCorrect)
      `ERECC_CMP("bdetect", {8{eb[64]}}, bErrorDetect)
      for (int c = 0; c < 8; c++) begin
        xb = (eb[63:0] + 64'(c)) ^ 64'(eb[67]);
        if (eb[66]) `ERECC_CMP("bdata", xb, bRdData[c])
      end
    end
  end

  // modes: plain, piped, correction off; bursts of 1..3 narrow bits,
  // single wide flips on even words, double on odd; with correction off
  // data bit 0 is flipped in store and must come back flipped
  initial begin
    repeat (10) @(posedge core_clk);
    `ERECC_CMP("aflg", 3'h0, {aRdValid, aErrFlag, aUncorrectableFlag})
    `ERECC_CMP("adat", 32'h0, aRdData)
    `ERECC_CMP("bflg", 24'h0, {bRdValid, bErrorCorrect, bErrorDetect})
    `ERECC_CMP("bdat", 512'h0, bRdData)
    reset <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      aPipeEn <= (m == 1);
      aEccEn <= (m != 2);
      bEccEn <= (m != 2);
      for (int i = 0; i < 16; i++) begin
        @(posedge core_clk);
        wd[i] = {rnd(), rnd()};
        w = 32'(rnd() % 3 + 1);
        p = 32'(rnd() % 72);
        wr <= 1'b1;
        addr <= 9'(i);
        data <= wd[i];
        aFlip <= (m == 2) ? 48'h200 :
          ((48'h1 << w) - 48'h1) << (rnd() % (49 - w));
        bFlip <= (m == 2) ? 72'h8 : (72'h1 << p) |
          ((i % 2) ? 72'h1 << ((p + 1 + rnd() % 71) % 72) : '0);
      end
      for (int i = 0; i < 16; i++) begin
        @(posedge core_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= 9'(i);
        qa.push_back({1'b1, m != 2, 1'b0, wd[i][31:0] ^ 32'(m == 2)});
        qb.push_back({m == 2, m == 2 || i % 2 == 0, m != 2 && i % 2 == 0,
          m != 2 && i % 2 == 1, wd[i]});
      end
      @(posedge core_clk);
      rd <= 1'b0;
      for (int k = 0; k < 8 && qa.size() + qb.size() > 0; k++)
        @(posedge core_clk);
      if (qa.size() + qb.size() > 0) begin
        errCount++;
        reportAndStop();
      end
    end
    reportAndStop();
  end
endmodule // erecc_top_tb

/* sim/erecc_user_model.sv */
// partner: user logic issuing whole-word requests on both styles
`timescale 1ns/1ns
module erecc_user_model (
  // requests from the bench
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [8:0]  addr,
  input wire logic [63:0] data,
  input wire logic [47:0] aFlip,
  input wire logic [71:0] bFlip,
  // memory ports
  output logic            aWrEn,
  output logic [8:0]      aWrAddr,
  output logic [31:0]     aWrData,
  output logic [47:0]     aWrFlip,
  output logic            aRdEn,
  output logic [8:0]      aRdAddr,
  output logic [7:0]      bWrEn,
  output logic [7:0][7:0] bWrAddr,
  output logic [7:0][63:0] bWrData,
  output logic [7:0][71:0] bWrFlip,
  output logic [7:0]      bRdEn,
  output logic [7:0][7:0] bRdAddr
);
  // whole words only: no partial-write path exists on this side
  assign aWrEn   = wr;
  assign aWrAddr = addr;
  assign aWrData = data[31:0];
  assign aWrFlip = aFlip;
  assign aRdEn   = rd;
  assign aRdAddr = addr;
  // channels get distinct words so a crossed channel shows up
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      bWrEn[c]   = wr;
      bWrAddr[c] = addr[7:0];
      bWrData[c] = data + 64'(c);
      bWrFlip[c] = bFlip;
      bRdEn[c]   = rd;
      bRdAddr[c] = addr[7:0];
    end
  end
endmodule // erecc_user_model
